/* rtl/mps_pkg.sv */
package mps_pkg;

    // clock rate and the one-minute prescaler
    localparam int unsigned MPS_CLK_HZ        = 20_000_000;
    localparam int unsigned MPS_MINUTE_S      = 60;
    localparam int unsigned MPS_MINUTE_CYCLES = MPS_MINUTE_S * MPS_CLK_HZ;
    localparam int unsigned MPS_PRESC_W       = 31;

    // register byte offsets
    localparam logic [7:0] MPS_OFS_CTRL      = 8'h00;
    localparam logic [7:0] MPS_OFS_CMDWORD   = 8'h04;
    localparam logic [7:0] MPS_OFS_STATUS    = 8'h08;
    localparam logic [7:0] MPS_OFS_IRQ_STAT  = 8'h0c;
    localparam logic [7:0] MPS_OFS_IRQ_MASK  = 8'h10;

    // ctrl field positions
    localparam int unsigned MPS_CTRL_SRC_LSB   = 0;
    localparam int unsigned MPS_CTRL_LEVEL_LSB = 8;
    localparam int unsigned MPS_CTRL_DELAY_LSB = 16;

    // request source codes; 3..7 pick control word bits 11..15
    localparam logic [2:0] MPS_SRC_NONE  = 3'h0;
    localparam logic [2:0] MPS_SRC_DI3   = 3'h1;
    localparam logic [2:0] MPS_SRC_DI4   = 3'h2;
    localparam logic [3:0] MPS_VIRT_OFS  = 4'h8;

    // setting limits and reset values
    localparam logic [6:0] MPS_LEVEL_MAX = 7'h64;
    localparam logic [6:0] MPS_LEVEL_RST = 7'h00;
    localparam logic [9:0] MPS_DELAY_MAX = 10'h3e7;
    localparam logic [9:0] MPS_DELAY_RST = 10'h005;
    localparam logic [7:0] MPS_DEMAND_MIN = 8'h01;

    // interrupt bit positions
    localparam int unsigned MPS_IRQ_REQ   = 0;
    localparam int unsigned MPS_IRQ_START = 1;
    localparam int unsigned MPS_IRQ_END   = 2;
    localparam int unsigned MPS_IRQ_W     = 3;

    // sequencer states, gray along idle -> wait -> heat
    typedef enum logic [1:0] {
        MPS_IDLE = 2'b00,
        MPS_WAIT = 2'b01,
        MPS_HEAT = 2'b11
    } mps_state_type;

    // software settings
    typedef struct packed {
        logic [9:0] warming_delay_minutes;
        logic [6:0] warming_current_level;
        logic [2:0] warming_request_source;
    } mps_ctrl_type;

    // drive outputs toward the firing stage
    typedef struct packed {
        logic       heat_enable;
        logic       hold_rotor;
        logic       thermal_suspend;
        logic       warming_status_indication;
        logic [7:0] current_demand;
    } mps_drive_type;

endpackage

/* rtl/mps_in_sync.sv */
module mps_in_sync #(
    parameter int unsigned W = 3
) (
    // clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // asynchronous pins and their settled copies
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out
);

    // one three-stage chain per pin
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++)
        begin : g_bit
            logic s1_r;   // metastable stage, read by s2 only
            logic s2_r;   // second stage
            logic s3_r;   // third stage
            logic out_r;  // settled level

            // shift chain
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                end
                else
                begin
                    s1_r <= pin_in[gi];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                end
            end

            // accept a change only once two stages agree
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    out_r <= 1'b0;
                else if (s2_r == s3_r)
                    out_r <= s2_r;
            end

            assign pin_out[gi] = out_r;
        end
    endgenerate

endmodule

/* rtl/mps_motor_preheat_sequencer.sv */
// Local design decisions: the register offsets and register access over AHB-Lite.
module mps_motor_preheat_sequencer
    import mps_pkg::*;
#(
    parameter int unsigned MINUTE_CYCLES = mps_pkg::MPS_MINUTE_CYCLES
) (
    // clock and reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // ahb-lite slave
    input  wire logic                  hsel,
    input  wire logic [7:0]            haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // terminal pins
    input  wire logic                  digital_input_three,
    input  wire logic                  digital_input_four,
    input  wire logic                  stop_terminal,
    // starter command path, same clock
    input  wire logic                  motor_stopped,
    input  wire logic                  run_order,
    input  wire logic                  stop_order,
    input  wire logic                  restart_lockout_time,
    // configuration that rules the function out
    input  wire logic                  cascade_en,
    input  wire logic                  inside_delta,
    input  wire logic                  two_wire_ctrl,
    // drive and interrupt
    output mps_pkg::mps_drive_type     drive,
    output logic                       irq
);
    import mps_pkg::*;

    // settled pins: [0] input three, [1] input four, [2] stop terminal
    logic [2:0]                 pins_s;
    // register state
    mps_ctrl_type               ctrl_r;
    logic [15:0]                cmd_word_r;
    logic [MPS_IRQ_W-1:0]       irq_stat_r;
    logic [MPS_IRQ_W-1:0]       irq_stat_nxt;
    logic [MPS_IRQ_W-1:0]       irq_mask_r;
    // bus phase tracking
    logic                       wr_pend_r;
    logic                       rd_pend_r;
    logic                       rd_done_r;
    logic [7:0]                 addr_r;
    logic [31:0]                hrdata_r;
    logic [31:0]                rd_mux;
    // timers and sequencer
    logic [MPS_PRESC_W-1:0]     presc_r;
    logic [9:0]                 minutes_r;
    logic                       delay_elapsed;
    mps_state_type              state_r;
    mps_state_type              state_nxt;
    logic                       block_r;
    logic                       req_sel;
    logic                       func_ok;
    logic                       start_ok;
    logic                       end_cond;
    logic                       heating;
    logic [7:0]                 demand_r;
    logic [MPS_IRQ_W-1:0]       events;

    // pin synchroniser bank
    mps_in_sync #(
        .W       (3)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin_in  ({stop_terminal, digital_input_four, digital_input_three}),
        .pin_out (pins_s)
    );

    // ahb phase capture; reads take one wait so data come from a flop
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            rd_done_r <= 1'b0;
            addr_r    <= 8'h00;
        end
        else
        begin
            rd_done_r <= rd_pend_r;
            if (hready && !rd_pend_r)
            begin
                wr_pend_r <= hsel && htrans[1] && hwrite;
                rd_pend_r <= hsel && htrans[1] && !hwrite;
                addr_r    <= haddr;
            end
            else
            begin
                wr_pend_r <= 1'b0;
                rd_pend_r <= 1'b0;
            end
        end
    end

    // read multiplexer; unmapped offsets read zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (addr_r)
            MPS_OFS_CTRL:
            begin
                rd_mux[MPS_CTRL_SRC_LSB +: 3] = ctrl_r.warming_request_source;
                if (ctrl_r.warming_request_source != MPS_SRC_NONE)
                begin
                    rd_mux[MPS_CTRL_LEVEL_LSB +: 7] =
                        ctrl_r.warming_current_level;
                    rd_mux[MPS_CTRL_DELAY_LSB +: 10] =
                        ctrl_r.warming_delay_minutes;
                end
            end
            MPS_OFS_CMDWORD:  rd_mux[15:0] = cmd_word_r;
            MPS_OFS_STATUS:
            begin
                rd_mux[0]     = drive.warming_status_indication;
                rd_mux[1]     = heating;
                rd_mux[2]     = delay_elapsed;
                rd_mux[3]     = motor_stopped;
                rd_mux[4]     = restart_lockout_time;
                rd_mux[5]     = !func_ok;
                rd_mux[25:16] = minutes_r;
            end
            MPS_OFS_IRQ_STAT: rd_mux[MPS_IRQ_W-1:0] = irq_stat_r;
            MPS_OFS_IRQ_MASK: rd_mux[MPS_IRQ_W-1:0] = irq_mask_r;
            default:          rd_mux = 32'h0000_0000;
        endcase
    end

    // read data register, loaded in the wait cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_r <= 32'h0000_0000;
        else if (rd_pend_r)
            hrdata_r <= rd_mux;
    end

    assign hrdata    = hrdata_r;
    assign hreadyout = !rd_pend_r;
    assign hresp     = 1'b0;

    // settings and control word; out-of-range values clamp
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_r.warming_request_source <= MPS_SRC_NONE;
            ctrl_r.warming_current_level  <= MPS_LEVEL_RST;
            ctrl_r.warming_delay_minutes  <= MPS_DELAY_RST;
            cmd_word_r                    <= 16'h0000;
            irq_mask_r                    <= '0;
        end
        else if (wr_pend_r)
        begin
            unique case (addr_r)
                MPS_OFS_CTRL:
                begin
                    ctrl_r.warming_request_source <=
                        hwdata[MPS_CTRL_SRC_LSB +: 3];
                    ctrl_r.warming_current_level <=
                        (hwdata[MPS_CTRL_LEVEL_LSB +: 7] > MPS_LEVEL_MAX) ?
                        MPS_LEVEL_MAX : hwdata[MPS_CTRL_LEVEL_LSB +: 7];
                    ctrl_r.warming_delay_minutes <=
                        (hwdata[MPS_CTRL_DELAY_LSB +: 10] > MPS_DELAY_MAX) ?
                        MPS_DELAY_MAX : hwdata[MPS_CTRL_DELAY_LSB +: 10];
                end
                MPS_OFS_CMDWORD:  cmd_word_r <= hwdata[15:0];
                MPS_OFS_IRQ_MASK: irq_mask_r <= hwdata[MPS_IRQ_W-1:0];
                default:
                begin
                    cmd_word_r <= cmd_word_r;
                end
            endcase
        end
    end

    // interrupt status: write one clears, a new event wins over the clear
    always_comb
    begin
        irq_stat_nxt = irq_stat_r;
        if (wr_pend_r && addr_r == MPS_OFS_IRQ_STAT)
            irq_stat_nxt = irq_stat_nxt & ~hwdata[MPS_IRQ_W-1:0];
        irq_stat_nxt = irq_stat_nxt | events;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_stat_r <= '0;
        else
            irq_stat_r <= irq_stat_nxt;
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // minute prescaler and delay counter
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            presc_r   <= '0;
            minutes_r <= 10'h000;
        end
        else if (!motor_stopped)
        begin
            presc_r   <= '0;
            minutes_r <= 10'h000;
        end
        else if (stop_order)
        begin
            presc_r   <= '0;
            minutes_r <= 10'h000;
        end
        else if (presc_r == MPS_PRESC_W'(MINUTE_CYCLES - 1))
        begin
            presc_r <= '0;
            if (minutes_r != MPS_DELAY_MAX)
                minutes_r <= minutes_r + 10'h001;
        end
        else
            presc_r <= presc_r + MPS_PRESC_W'(1);
    end

    assign delay_elapsed = minutes_r >= ctrl_r.warming_delay_minutes;

    // selected request; virtual codes index control word bits 11..15
    always_comb
    begin
        req_sel = 1'b0;
        unique case (ctrl_r.warming_request_source)
            MPS_SRC_NONE: req_sel = 1'b0;
            MPS_SRC_DI3:  req_sel = pins_s[0];
            MPS_SRC_DI4:  req_sel = pins_s[1];
            default:
                req_sel = cmd_word_r[{1'b0, ctrl_r.warming_request_source}
                                     + MPS_VIRT_OFS];
        endcase
    end

    assign func_ok  = !(cascade_en || inside_delta || two_wire_ctrl);
    assign start_ok = motor_stopped && restart_lockout_time &&
                      delay_elapsed && pins_s[2];
    assign end_cond = !req_sel || run_order || stop_order || !func_ok;
    assign heating  = state_r == MPS_HEAT;

    // sequencer next state
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            MPS_IDLE:
            begin
                if (req_sel && func_ok && !block_r)
                    state_nxt = MPS_WAIT;
            end
            MPS_WAIT:
            begin
                if (end_cond)
                    state_nxt = MPS_IDLE;
                else if (start_ok)
                    state_nxt = MPS_HEAT;
            end
            MPS_HEAT:
            begin
                if (end_cond || !motor_stopped || !pins_s[2])
                    state_nxt = MPS_IDLE;
            end
            default: state_nxt = MPS_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            state_r <= MPS_IDLE;
        else
            state_r <= state_nxt;
    end

    // after a run or stop order the request must drop before re-arming,
    // otherwise a held input would silently restart heating later
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            block_r <= 1'b0;
        else if (state_r != MPS_IDLE && (run_order || stop_order))
            block_r <= 1'b1;
        else if (!req_sel)
            block_r <= 1'b0;
    end

    // current demand, one cycle behind the state
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            demand_r <= 8'h00;
        else if (heating)
            demand_r <= {1'b0, ctrl_r.warming_current_level}
                        + MPS_DEMAND_MIN;
        else
            demand_r <= 8'h00;
    end

    // drive bundle
    assign drive.heat_enable               = heating;
    assign drive.hold_rotor                = heating;
    assign drive.thermal_suspend           = heating;
    assign drive.warming_status_indication = state_r != MPS_IDLE;
    assign drive.current_demand            = demand_r;

    // events feeding the interrupt status
    assign events[MPS_IRQ_REQ]   = state_r == MPS_IDLE &&
                                   state_nxt == MPS_WAIT;
    assign events[MPS_IRQ_START] = state_nxt == MPS_HEAT && !heating;
    assign events[MPS_IRQ_END]   = heating && state_nxt != MPS_HEAT;

    // checks
    property p_start_pre;
        @(posedge hclk) disable iff (!hresetn)
        $rose(heating) |-> $past(start_ok && req_sel && func_ok);
    endproperty
    a_start_pre: assert property (p_start_pre)
        else $error("heating began without its preconditions");

    property p_end_orders;
        @(posedge hclk) disable iff (!hresetn)
        heating && (run_order || stop_order || !req_sel) |=> !heating;
    endproperty
    a_end_orders: assert property (p_end_orders)
        else $error("heating survived an end condition");

    property p_stop_restart;
        @(posedge hclk) disable iff (!hresetn)
        stop_order |=> minutes_r == 10'h000 && presc_r == '0;
    endproperty
    a_stop_restart: assert property (p_stop_restart)
        else $error("delay not restarted by stop order");

    property p_delay_full;
        @(posedge hclk) disable iff (!hresetn)
        heating |-> minutes_r >= ctrl_r.warming_delay_minutes;
    endproperty
    a_delay_full: assert property (p_delay_full)
        else $error("heating before delay expired");

    property p_both_timers;
        @(posedge hclk) disable iff (!hresetn)
        $rose(heating) |-> $past(restart_lockout_time && delay_elapsed);
    endproperty
    a_both_timers: assert property (p_both_timers)
        else $error("heating before both timers expired");

    property p_level;
        @(posedge hclk) disable iff (!hresetn)
        heating |=> demand_r ==
            {1'b0, $past(ctrl_r.warming_current_level)} + MPS_DEMAND_MIN;
    endproperty
    a_level: assert property (p_level)
        else $error("demand does not follow level");

    property p_nonzero;
        @(posedge hclk) disable iff (!hresetn)
        heating ##1 heating |-> demand_r != 8'h00;
    endproperty
    a_nonzero: assert property (p_nonzero)
        else $error("zero demand while heating");

    property p_status_wait;
        @(posedge hclk) disable iff (!hresetn)
        state_r == MPS_WAIT |-> drive.warming_status_indication &&
                                !drive.heat_enable;
    endproperty
    a_status_wait: assert property (p_status_wait)
        else $error("status missing while waiting");

    property p_none_idle;
        @(posedge hclk) disable iff (!hresetn)
        ctrl_r.warming_request_source == MPS_SRC_NONE &&
        state_r == MPS_IDLE |=> state_r == MPS_IDLE;
    endproperty
    a_none_idle: assert property (p_none_idle)
        else $error("left idle with no source");

    property p_incompat;
        @(posedge hclk) disable iff (!hresetn)
        (cascade_en || inside_delta || two_wire_ctrl) |=>
            state_r == MPS_IDLE;
    endproperty
    a_incompat: assert property (p_incompat)
        else $error("sequencer active in incompatible setup");

    property p_run_clear;
        @(posedge hclk) disable iff (!hresetn)
        !motor_stopped |=> minutes_r == 10'h000;
    endproperty
    a_run_clear: assert property (p_run_clear)
        else $error("delay kept while motor running");

    c_heat: cover property (@(posedge hclk) disable iff (!hresetn)
        $rose(heating));
    c_run_end: cover property (@(posedge hclk) disable iff (!hresetn)
        heating && run_order);
    c_wait: cover property (@(posedge hclk) disable iff (!hresetn)
        state_r == MPS_WAIT && !delay_elapsed);

endmodule

/* tb/mps_operator_model.sv */
module mps_operator_model (
    // clock
    input  wire logic hclk,
    // what the operator wants on the terminals
    input  wire logic want_three,
    input  wire logic want_four,
    input  wire logic want_stop,
    // terminal pins toward the starter
    output logic      digital_input_three,
    output logic      digital_input_four,
    output logic      stop_terminal
);
    timeunit 1ns;
    timeprecision 1ns;

    // pins move just after an edge and stay as plain levels
    // request held steady
    always_ff @(posedge hclk)
    begin
        digital_input_three <= want_three;
        digital_input_four  <= want_four;
        stop_terminal       <= want_stop;
    end
endmodule

/* tb/testbench.sv */
`define CHK(nm, e, g) \
    begin \
        check_count++; \
        if ((g) !== (e)) \
        begin \
            n_errors++; \
            $display("BAD %s exp %h got %h", nm, e, g); \
        end \
    end

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import mps_pkg::*;

    // bus side
    logic          hclk, hresetn, hwrite, hreadyout, hresp, irq;
    logic [7:0]    haddr;
    logic [1:0]    htrans;
    logic [31:0]   hwdata, hrdata, rd;
    // starter command path and config
    logic          motor_stopped, run_order, stop_order, lockout;
    logic          cascade_en, inside_delta, two_wire_ctrl;
    // operator wishes and pins
    logic          want3, want4, want_stop, di3, di4, stop_t;
    mps_drive_type drive;
    int            n_errors, check_count;

    // short minute so delays take a few cycles
    mps_motor_preheat_sequencer #(.MINUTE_CYCLES(8)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .digital_input_three(di3),
        .digital_input_four(di4), .stop_terminal(stop_t),
        .motor_stopped(motor_stopped), .run_order(run_order),
        .stop_order(stop_order), .restart_lockout_time(lockout),
        .cascade_en(cascade_en), .inside_delta(inside_delta),
        .two_wire_ctrl(two_wire_ctrl), .drive(drive), .irq(irq));

    mps_operator_model i_oper (
        .hclk(hclk), .want_three(want3), .want_four(want4),
        .want_stop(want_stop), .digital_input_three(di3),
        .digital_input_four(di4), .stop_terminal(stop_t));

    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // waits for hready at a rising edge; data is stable just before it
    task automatic wait_rdy(output logic [31:0] d);
        int n;
        n = 0;
        do
        begin
            @(negedge hclk);
            d = hrdata;
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
        begin
            n_errors++;
            end_sim();
        end
        else
            @(posedge hclk);
    endtask

    // one single word transfer, entered just after a rising edge
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] q);
        logic [31:0] d;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= w;
        wait_rdy(d);
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy(q);
    endtask

    // bounded wait for the heating output to reach a level
    task automatic wait_heat(input logic v);
        int n;
        n = 0;
        while (drive.heat_enable !== v && n < 60)
        begin
            @(negedge hclk);
            n++;
        end
        `CHK("heat_enable", v, drive.heat_enable)
        // a level never reached ends the run here
        if (drive.heat_enable !== v)
            end_sim();
        else
            @(posedge hclk);
    endtask

    task automatic pulse(input logic is_run);
        run_order  <= is_run;
        stop_order <= !is_run;
        @(posedge hclk);
        run_order  <= 1'b0;
        stop_order <= 1'b0;
        @(posedge hclk);
    endtask

    // register defaults, clamping, hidden fields, unmapped place
    task automatic s_regs();
        ahb(1'b0, MPS_OFS_CTRL, 32'h0, rd);
        `CHK("ctrl rst", 32'h0000_0000, rd)
        ahb(1'b1, MPS_OFS_CTRL, 32'h0000_7801, rd);
        ahb(1'b0, MPS_OFS_CTRL, 32'h0, rd);
        `CHK("ctrl clamp", 32'h0000_6401, rd)
        ahb(1'b0, 8'h14, 32'h0, rd);
        `CHK("unmapped", 32'h0000_0000, rd)
        ahb(1'b1, MPS_OFS_IRQ_MASK, 32'h0000_0007, rd);
    endtask

    // heat on input three, end by run and by stop order
    task automatic s_heat();
        want3 <= 1'b1;
        wait_heat(1'b1);
        // demand settles one cycle after heat; look mid-cycle
        @(negedge hclk);
        `CHK("hold", 1'b1, drive.hold_rotor)
        `CHK("thermal", 1'b1, drive.thermal_suspend)
        `CHK("demand", 8'h65, drive.current_demand)
        `CHK("irq", 1'b1, irq)
        @(posedge hclk);
        pulse(1'b1);
        wait_heat(1'b0);
        want3 <= 1'b0;
        repeat (8) @(posedge hclk);
        want3 <= 1'b1;
        wait_heat(1'b1);
        pulse(1'b0);
        wait_heat(1'b0);
        want3 <= 1'b0;
        ahb(1'b1, MPS_OFS_IRQ_STAT, 32'h0000_0007, rd);
        ahb(1'b0, MPS_OFS_IRQ_STAT, 32'h0, rd);
        `CHK("irq clr", 32'h0000_0000, rd)
        `CHK("irq low", 1'b0, irq)
    endtask

    // input four request, stop terminal drop, motor start, bad config
    task automatic s_di4();
        ahb(1'b1, MPS_OFS_CTRL, 32'h0000_0502, rd);
        want4 <= 1'b1;
        wait_heat(1'b1);
        @(negedge hclk);
        `CHK("level 5", 8'h06, drive.current_demand)
        @(posedge hclk);
        want_stop <= 1'b0;
        wait_heat(1'b0);
        want_stop <= 1'b1;
        wait_heat(1'b1);
        motor_stopped <= 1'b0;
        wait_heat(1'b0);
        ahb(1'b0, MPS_OFS_STATUS, 32'h0, rd);
        `CHK("status run", 32'h0000_0015, rd)
        `CHK("hresp", 1'b0, hresp)
        inside_delta <= 1'b1;
        ahb(1'b0, MPS_OFS_STATUS, 32'h0, rd);
        `CHK("status delta", 32'h0000_0034, rd)
        // let the request fall while the delta config still rules the function out, then restore
        want4 <= 1'b0;
        repeat (8) @(posedge hclk);
        {inside_delta, motor_stopped} <= 2'b01;
    endtask

    // virtual request with a two minute delay, then lockout overlap
    task automatic s_delay();
        ahb(1'b1, MPS_OFS_CTRL, 32'h0002_0003, rd);
        pulse(1'b0);
        ahb(1'b1, MPS_OFS_CMDWORD, 32'h0000_0800, rd);
        repeat (2) @(negedge hclk);
        `CHK("status", 1'b1, drive.warming_status_indication)
        `CHK("early", 1'b0, drive.heat_enable)
        wait_heat(1'b1);
        @(negedge hclk);
        `CHK("min demand", 8'h01, drive.current_demand)
        @(posedge hclk);
        ahb(1'b1, MPS_OFS_CMDWORD, 32'h0, rd);
        wait_heat(1'b0);
        lockout <= 1'b0;
        pulse(1'b0);
        ahb(1'b1, MPS_OFS_CMDWORD, 32'h0000_0800, rd);
        repeat (30) @(posedge hclk);
        `CHK("locked", 1'b0, drive.heat_enable)
        lockout <= 1'b1;
        repeat (4) @(negedge hclk);
        `CHK("overlap", 1'b1, drive.heat_enable)
        @(posedge hclk);
        cascade_en <= 1'b1;
        wait_heat(1'b0);
    endtask

    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    initial
    begin
        {hresetn, hwrite, run_order, stop_order, cascade_en} = '0;
        {inside_delta, two_wire_ctrl, want3, want4} = '0;
        {motor_stopped, lockout, want_stop} = 3'b111;
        haddr  = 8'h00;
        htrans = 2'b00;
        hwdata = 32'h0;
        n_errors = 0;
        check_count = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (6) @(posedge hclk);
        s_regs();
        s_heat();
        s_di4();
        s_delay();
        end_sim();
    end
endmodule
